// file: hw/mlsc_pkg.sv
// package: constants and types for the mux line setup control block
package mlsc_pkg;
  localparam int NUM_LINES = 16;
  localparam int SEL_W = 4;
  // scan control/status field positions
  localparam int SCS_SEL_LO = 0;
  localparam int SCS_BUSY_BIT = 4;
  localparam int SCS_IE_BIT = 6;
  localparam int SCS_CLR_MUX_BIT = 10;
  localparam int SCS_CLR_SCAN_BIT = 11;
  localparam int SCS_DSR_CHG_BIT = 12;
  localparam int SCS_CTS_CHG_BIT = 13;
  localparam int SCS_CAR_CHG_BIT = 14;
  localparam int SCS_RING_BIT = 15;
  // line modem status field positions
  localparam int LMS_EN_BIT = 0;
  localparam int LMS_DTR_BIT = 1;
  localparam int LMS_RTS_BIT = 2;
  localparam int LMS_DSR_BIT = 4;
  // system control field positions
  localparam int SYS_GO_BIT = 0;
  localparam int SYS_XA_LO = 4;
  localparam int SYS_IE0_BIT = 6;
  localparam int SYS_MCLR_BIT = 11;
  localparam int SYS_IE1_BIT = 12;
  localparam int SYS_IE2_BIT = 13;
  // line control field positions
  localparam int LC_ALT_SYNC_BIT = 10;
  localparam int LC_RX_EN_BIT = 13;
  localparam int LC_SYNC_SRCH_BIT = 15;
  // line state / progress positions
  localparam int LS_RX_ACT_BIT = 0;
  localparam int LS_RESYNC_BIT = 1;
  localparam int LS_TX_GO_BIT = 2;
  localparam int LS_ALT_START_BIT = 7;
  localparam int LP_RESYNC_EXP_BIT = 7;
  localparam int BC_UNMARK_BIT = 15;
  // timing: clear-scan busy hold
  localparam int CLK_MHZ = 125;
  localparam int CLR_SCAN_NS = 64;
  localparam int CLR_SCAN_CYC = (CLR_SCAN_NS * CLK_MHZ + 999) / 1000;
  localparam logic [3:0] CLR_SCAN_CNT = 4'(CLR_SCAN_CYC);
  localparam logic [15:0] WORD_RST = 16'h0000;
  typedef enum logic [1:0] {MLSC_HALT, MLSC_IDLE, MLSC_RUN} mlsc_seq_t;
endpackage : mlsc_pkg

// file: hw/mlsc_top.sv
// design: per-line setup, modem scan, resync and termination control
// Behaviour
// - interrupt enable bit selects scanner interrupt mode
// - line enable write enables selected line
// - bus init clears scan and modem registers
// - clear-mux/clear-scan act as init; mux drops DTR
// - busy held during clear-scan; software waits
// - master clear zeroes the system control register and halts the sequencer
// - processor-go starts sequencer into idle loop, or straight into run if the SEC_LINE line is active
// - go write also loads address and enables
// - preloaded non-zero mode becomes initial mode
// - rx enable plus sync search starts reception
// - count bit 15 zero marks the count
// - line state bit 07 starts from alternate
// - transmitter-go write starts line transmission
// - scan register flags modem transitions on line
// - modem register drives DTR, RTS; shows DSR
// - resync sets expected flag, discards, searches
// - sync found sets receiver active
// - device clears tx-go at end or error
// - shutdown clears resync, active, discards characters
`timescale 1ns/1ps
`default_nettype none
module mlsc_top import mlsc_pkg::*; #(
  parameter int LINES = NUM_LINES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  input wire logic BUS_INIT,
  // scan control/status writes
  input wire logic SCS_WR,
  input wire logic [15:0] SCS_WDATA,
  output logic [15:0] SCS_RDATA,
  // line modem status writes (selected line)
  input wire logic LMS_WR,
  input wire logic [15:0] LMS_WDATA,
  output logic [15:0] LMS_RDATA,
  // system control writes
  input wire logic SYS_WR,
  input wire logic [15:0] SYS_WDATA,
  output logic [15:0] SYS_RDATA,
  output logic SEQ_IDLE,
  // per-line secondary writes, line chosen by SEC_LINE
  input wire logic [3:0] SEC_LINE,
  input wire logic LC_WR,
  input wire logic [15:0] LC_WDATA,
  input wire logic LS_WR,
  input wire logic [15:0] LS_WDATA,
  input wire logic RXM_WR,
  input wire logic TXM_WR,
  input wire logic [2:0] MODE_WDATA,
  // transmitter byte counts of SEC_LINE
  input wire logic [15:0] PRI_COUNT,
  input wire logic [15:0] ALT_COUNT,
  input wire logic TX_MEM_ERR,
  // receiver events of SEC_LINE
  input wire logic SYNC_FOUND,
  // line status readback for SEC_LINE
  output logic [15:0] LS_RDATA,
  output logic [15:0] LP_RDATA,
  output logic [2:0] RXM_RDATA,
  output logic [2:0] TXM_RDATA,
  output logic [15:0] LC_RDATA,
  output logic TX_USE_ALT,
  output logic TX_MARKED,
  output logic RX_DISCARD,
  // modem pins per line
  input wire logic [15:0] DSR_IN,
  input wire logic [15:0] CTS_IN,
  input wire logic [15:0] CAR_IN,
  input wire logic [15:0] RING_IN,
  output logic [15:0] DTR_OUT,
  output logic [15:0] RTS_OUT,
  output logic [15:0] LINE_EN_OUT,
  output logic SCAN_IRQ_MODE
);
  // all state but the reset release chain in one struct
  typedef struct packed {
    logic [3:0] sel;
    logic ie;
    logic [3:0] busy_cnt;
    logic dsr_chg;
    logic cts_chg;
    logic car_chg;
    logic ring;
    logic [15:0] en;
    logic [15:0] dtr;
    logic [15:0] rts;
    logic [15:0] dsr_q;
    logic [15:0] cts_q;
    logic [15:0] car_q;
    logic [15:0] ring_q;
    logic [15:0] sys;
    mlsc_seq_t seq;
    logic [15:0][15:0] lc;
    logic [15:0][7:0] ls;
    logic [15:0] resync_exp;
    logic [15:0][2:0] rxm;
    logic [15:0][2:0] txm;
    logic discard;
  } mlsc_state_t;
  mlsc_state_t st_ff, nxt_st;
  // release chain lives apart from the struct: it alone runs on the raw reset
  logic [1:0] rst_sync_ff;
  logic rst_n_i;
  assign rst_n_i = rst_sync_ff[1];
  // reset release through two flops
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  // remaining state on synchronised reset copy
  always_ff @(posedge CLK or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  // next-state logic
  always_comb begin
    logic clr_mux;
    logic clr_scan;
    logic init_scan;
    logic [3:0] s;
    clr_mux = SCS_WR && SCS_WDATA[SCS_CLR_MUX_BIT];
    clr_scan = SCS_WR && SCS_WDATA[SCS_CLR_SCAN_BIT];
    init_scan = BUS_INIT || clr_mux || clr_scan;
    s = SEC_LINE;
    nxt_st = st_ff;
    nxt_st.discard = 1'b0;
    // sample modem pins for transitions
    nxt_st.dsr_q = DSR_IN;
    nxt_st.cts_q = CTS_IN;
    nxt_st.car_q = CAR_IN;
    nxt_st.ring_q = RING_IN;
    if (st_ff.busy_cnt != 4'h0) begin
      nxt_st.busy_cnt = st_ff.busy_cnt - 4'h1;
    end
    // scan register write: select and mode
    if (SCS_WR && !init_scan) begin
      nxt_st.sel = SCS_WDATA[SCS_SEL_LO +: SEL_W];
      nxt_st.ie = SCS_WDATA[SCS_IE_BIT];
      // writing a one to a change flag clears it
      if (SCS_WDATA[SCS_DSR_CHG_BIT]) nxt_st.dsr_chg = 1'b0;
      if (SCS_WDATA[SCS_CTS_CHG_BIT]) nxt_st.cts_chg = 1'b0;
      if (SCS_WDATA[SCS_CAR_CHG_BIT]) nxt_st.car_chg = 1'b0;
      if (SCS_WDATA[SCS_RING_BIT]) nxt_st.ring = 1'b0;
    end
    // modem writes land on selected line only
    if (LMS_WR) begin
      nxt_st.en[st_ff.sel] = LMS_WDATA[LMS_EN_BIT];
      nxt_st.dtr[st_ff.sel] = LMS_WDATA[LMS_DTR_BIT];
      nxt_st.rts[st_ff.sel] = LMS_WDATA[LMS_RTS_BIT];
    end
    // transitions on selected enabled line; set wins over clear
    if (st_ff.en[st_ff.sel]) begin
      if (DSR_IN[st_ff.sel] != st_ff.dsr_q[st_ff.sel]) nxt_st.dsr_chg = 1'b1;
      if (CTS_IN[st_ff.sel] != st_ff.cts_q[st_ff.sel]) nxt_st.cts_chg = 1'b1;
      if (CAR_IN[st_ff.sel] != st_ff.car_q[st_ff.sel]) nxt_st.car_chg = 1'b1;
      if (RING_IN[st_ff.sel] && !st_ff.ring_q[st_ff.sel]) nxt_st.ring = 1'b1;
    end
    // init clears scan and modem registers; dtr only on clear-mux or bus init
    if (init_scan) begin
      nxt_st.sel = 4'h0;
      nxt_st.ie = 1'b0;
      nxt_st.dsr_chg = 1'b0;
      nxt_st.cts_chg = 1'b0;
      nxt_st.car_chg = 1'b0;
      nxt_st.ring = 1'b0;
      nxt_st.en = 16'h0000;
      nxt_st.rts = 16'h0000;
      if (clr_mux || BUS_INIT) nxt_st.dtr = 16'h0000;
    end
    if (clr_scan) nxt_st.busy_cnt = CLR_SCAN_CNT;
    // system control: master clear beats everything else in the word
    if (SYS_WR) begin
      if (SYS_WDATA[SYS_MCLR_BIT]) begin
        nxt_st.sys = WORD_RST;
        nxt_st.seq = MLSC_HALT;
      end else begin
        nxt_st.sys = SYS_WDATA & 16'h3071;
        if (SYS_WDATA[SYS_GO_BIT]) nxt_st.seq = MLSC_IDLE;
        else nxt_st.seq = MLSC_HALT;
      end
    end else if (BUS_INIT) begin
      nxt_st.sys = WORD_RST;
      nxt_st.seq = MLSC_HALT;
    end
    // sequencer loops idle until the SEC_LINE line has rx enable or tx-go set
    unique case (nxt_st.seq)
      MLSC_HALT: ;
      MLSC_IDLE, MLSC_RUN: begin
        nxt_st.seq = (|st_ff.lc[s][LC_RX_EN_BIT] || |st_ff.ls[s][LS_TX_GO_BIT]) ?
          MLSC_RUN : MLSC_IDLE;
      end
    endcase
    // secondary register writes for SEC_LINE
    if (LC_WR) nxt_st.lc[s] = LC_WDATA;
    if (RXM_WR) nxt_st.rxm[s] = MODE_WDATA;
    if (TXM_WR) nxt_st.txm[s] = MODE_WDATA;
    if (LS_WR) begin
      nxt_st.ls[s] = LS_WDATA[7:0];
      if (LS_WDATA[LS_RESYNC_BIT]) begin
        // resync or shutdown: flag, drop buffered data, search again
        nxt_st.resync_exp[s] = 1'b1;
        nxt_st.discard = 1'b1;
        nxt_st.ls[s][LS_RESYNC_BIT] = 1'b0;
        nxt_st.ls[s][LS_RX_ACT_BIT] = 1'b0;
      end
    end else if (SYNC_FOUND && st_ff.lc[s][LC_RX_EN_BIT] && st_ff.lc[s][LC_SYNC_SRCH_BIT]) begin
      nxt_st.ls[s][LS_RX_ACT_BIT] = 1'b1;
      nxt_st.resync_exp[s] = 1'b0;
    end
    // transmitter end or memory error stops the line
    if (!LS_WR && st_ff.ls[s][LS_TX_GO_BIT] &&
        ((PRI_COUNT[14:0] == 15'h0 && ALT_COUNT[14:0] == 15'h0) || TX_MEM_ERR)) begin
      nxt_st.ls[s][LS_TX_GO_BIT] = 1'b0;
    end
  end
  // outputs
  assign SCS_RDATA = {st_ff.ring, st_ff.car_chg, st_ff.cts_chg, st_ff.dsr_chg, 5'h00,
                      st_ff.ie, 1'b0, st_ff.busy_cnt != 4'h0, st_ff.sel};
  assign LMS_RDATA = {11'h000, DSR_IN[st_ff.sel], 1'b0, st_ff.rts[st_ff.sel],
                      st_ff.dtr[st_ff.sel], st_ff.en[st_ff.sel]};
  assign SYS_RDATA = st_ff.sys;
  assign SEQ_IDLE = (st_ff.seq == MLSC_IDLE);
  assign LS_RDATA = {8'h00, st_ff.ls[SEC_LINE]};
  assign LP_RDATA = {8'h00, st_ff.resync_exp[SEC_LINE], 7'h00};
  assign RXM_RDATA = st_ff.rxm[SEC_LINE];
  assign TXM_RDATA = st_ff.txm[SEC_LINE];
  assign LC_RDATA = st_ff.lc[SEC_LINE];
  assign TX_USE_ALT = st_ff.ls[SEC_LINE][LS_ALT_START_BIT];
  assign TX_MARKED = !PRI_COUNT[BC_UNMARK_BIT] && PRI_COUNT[14:0] == 15'h0;
  assign RX_DISCARD = st_ff.discard;
  assign DTR_OUT = st_ff.dtr;
  assign RTS_OUT = st_ff.rts;
  assign LINE_EN_OUT = st_ff.en;
  assign SCAN_IRQ_MODE = st_ff.ie;

  // checks: each guards one rule of the design's side
  localparam int BUSY_CYC = CLR_SCAN_CYC; // busy span, kept local for the delay below
  // clear-scan raises busy on the very next cycle
  property p_busy_clr;
    @(posedge CLK) disable iff (!rst_n_i)
      (SCS_WR && SCS_WDATA[SCS_CLR_SCAN_BIT]) |=> SCS_RDATA[SCS_BUSY_BIT];
  endproperty
  a_busy_clr: assert property (p_busy_clr)
    else $error("busy not raised");
  // busy still up on the last counted cycle, gone on the one after
  property p_busy;
    @(posedge CLK) disable iff (!rst_n_i)
      (SCS_WR && SCS_WDATA[SCS_CLR_SCAN_BIT]) |-> ##BUSY_CYC SCS_RDATA[SCS_BUSY_BIT] ##1
      !SCS_RDATA[SCS_BUSY_BIT];
  endproperty
  a_busy: assert property (p_busy)
    else $error("busy span wrong");
  // clear-mux drops terminal ready on every line
  property p_mux_dtr;
    @(posedge CLK) disable iff (!rst_n_i)
      (SCS_WR && SCS_WDATA[SCS_CLR_MUX_BIT]) |=> DTR_OUT == 16'h0000;
  endproperty
  a_mux_dtr: assert property (p_mux_dtr)
    else $error("dtr kept after clear mux");
  // master clear empties the system control word
  property p_mclr;
    @(posedge CLK) disable iff (!rst_n_i)
      (SYS_WR && SYS_WDATA[SYS_MCLR_BIT]) |=> SYS_RDATA == 16'h0000;
  endproperty
  a_mclr: assert property (p_mclr)
    else $error("master clear missed");
  // go without master clear sticks
  property p_go;
    @(posedge CLK) disable iff (!rst_n_i)
      (SYS_WR && SYS_WDATA[SYS_GO_BIT] && !SYS_WDATA[SYS_MCLR_BIT]) |=> SYS_RDATA[SYS_GO_BIT];
  endproperty
  a_go: assert property (p_go)
    else $error("go lost");
  // resync flags the interval and drops buffered data; a line change hides the readback
  property p_resync;
    @(posedge CLK) disable iff (!rst_n_i)
      (LS_WR && LS_WDATA[LS_RESYNC_BIT]) |=> RX_DISCARD && LP_RDATA[LP_RESYNC_EXP_BIT] ||
      $past(SEC_LINE) != SEC_LINE;
  endproperty
  a_resync: assert property (p_resync)
    else $error("resync not handled");
  // memory error ends a running transmitter unless software writes the state word
  property p_tx_stop;
    @(posedge CLK) disable iff (!rst_n_i)
      (!LS_WR && LS_RDATA[LS_TX_GO_BIT] && TX_MEM_ERR) |=> !LS_RDATA[LS_TX_GO_BIT] ||
      $past(SEC_LINE) != SEC_LINE;
  endproperty
  a_tx_stop: assert property (p_tx_stop)
    else $error("transmitter kept running");
  // sync found while searching makes the receiver active
  property p_sync;
    @(posedge CLK) disable iff (!rst_n_i)
      (!LS_WR && SYNC_FOUND && LC_RDATA[LC_RX_EN_BIT] && LC_RDATA[LC_SYNC_SRCH_BIT]) |=>
      LS_RDATA[LS_RX_ACT_BIT] || $past(SEC_LINE) != SEC_LINE;
  endproperty
  a_sync: assert property (p_sync)
    else $error("receiver not active after sync");
  // main scenarios worth seeing
  c_resync: cover property (@(posedge CLK) LS_WR && LS_WDATA[LS_RESYNC_BIT]);
  c_clr: cover property (@(posedge CLK) SCS_WR && SCS_WDATA[SCS_CLR_SCAN_BIT]);
  c_go: cover property (@(posedge CLK) SYS_WR && SYS_WDATA[SYS_GO_BIT]);
  c_tx_end: cover property (@(posedge CLK) LS_RDATA[LS_TX_GO_BIT] ##1 !LS_RDATA[LS_TX_GO_BIT]);
endmodule // mlsc_top
`default_nettype wire

// file: verif/mlsc_modem_model.sv
// remote line modem model that answers the block's modem pins
`timescale 1ns/1ps
`default_nettype none
module mlsc_modem_model (
  // clock
  input wire logic clk,
  // local controls seen by the far modems
  input wire logic [15:0] dtr,
  input wire logic [15:0] rts,
  input wire logic [15:0] ring_req,
  // modem status back to the block
  output logic [15:0] dsr,
  output logic [15:0] cts,
  output logic [15:0] car,
  output logic [15:0] ring
);
  // a modem answers on the falling edge, half a cycle late, so status never moves on the sampling edge
  always @(negedge clk) begin
    dsr <= dtr; // set ready once terminal ready holds the call
    cts <= rts; // clear to send follows request to send
    car <= rts; // remote carrier comes up with the data mode
    ring <= ring_req; // ring only where the bench places a call
  end
endmodule : mlsc_modem_model
`default_nettype wire

// file: verif/tb.sv
// self-checking bench for the mux line setup control block
`timescale 1ns/1ps
`default_nettype none
module tb import mlsc_pkg::*;;
  // stimulus
  logic clk = 0, rst_n = 0, bus_init = 0, scs_wr = 0, lms_wr = 0, sys_wr = 0;
  logic lc_wr = 0, ls_wr = 0, rxm_wr = 0, txm_wr = 0, mem_err = 0, sync_found = 0, disc_seen;
  logic [15:0] wdata = 16'h0000, pri = 16'h8001, alt = 16'h0001, ring_req = 16'h0000;
  logic [3:0] sec_line = 4'h0;
  logic [2:0] mode = 3'h0;
  // observed
  logic [15:0] scs_rd, lms_rd, sys_rd, ls_rd, lp_rd, lc_rd, dsr, cts, car, ring, dtr, rts, len;
  logic [2:0] rxm_rd, txm_rd;
  logic seq_idle, use_alt, marked, discard, irq_mode;
  int fail_count = 0, num_checks = 0, n;
  always #4 clk = ~clk;
  mlsc_top u_mlsc_top (.CLK(clk), .RST_N(rst_n), .BUS_INIT(bus_init), .SCS_WR(scs_wr),
    .SCS_WDATA(wdata), .SCS_RDATA(scs_rd), .LMS_WR(lms_wr), .LMS_WDATA(wdata),
    .LMS_RDATA(lms_rd), .SYS_WR(sys_wr), .SYS_WDATA(wdata), .SYS_RDATA(sys_rd),
    .SEQ_IDLE(seq_idle), .SEC_LINE(sec_line), .LC_WR(lc_wr), .LC_WDATA(wdata), .LS_WR(ls_wr),
    .LS_WDATA(wdata), .RXM_WR(rxm_wr), .TXM_WR(txm_wr), .MODE_WDATA(mode), .PRI_COUNT(pri),
    .ALT_COUNT(alt), .TX_MEM_ERR(mem_err), .SYNC_FOUND(sync_found), .LS_RDATA(ls_rd),
    .LP_RDATA(lp_rd), .RXM_RDATA(rxm_rd), .TXM_RDATA(txm_rd), .LC_RDATA(lc_rd),
    .TX_USE_ALT(use_alt), .TX_MARKED(marked), .RX_DISCARD(discard), .DSR_IN(dsr),
    .CTS_IN(cts), .CAR_IN(car), .RING_IN(ring), .DTR_OUT(dtr), .RTS_OUT(rts),
    .LINE_EN_OUT(len), .SCAN_IRQ_MODE(irq_mode));
  mlsc_modem_model u_mlsc_modem_model (.clk(clk), .dtr(dtr), .rts(rts), .ring_req(ring_req),
    .dsr(dsr), .cts(cts), .car(car), .ring(ring));
  // compare one value, counting every check
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // verdict and end of run
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // one-cycle strobe: 0 scan, 1 modem, 2 system, 3 line ctl, 4 state, 5 rx mode, 6 tx mode
  task automatic wr(input int k, input logic [15:0] d);
    wdata = d;
    {txm_wr, rxm_wr, ls_wr, lc_wr, sys_wr, lms_wr, scs_wr} = 7'h01 << k;
    @(negedge clk);
    disc_seen = discard; // the discard pulse only stands this one cycle
    {txm_wr, rxm_wr, ls_wr, lc_wr, sys_wr, lms_wr, scs_wr} = 7'h00;
    @(negedge clk);
  endtask
  // select then enable, modem answers, flags follow the selected line
  task automatic t_modem();
    wr(0, 16'h0043);
    chk(16'(irq_mode), 16'h0001);
    wr(1, 16'h0007);
    chk(len, 16'h0008);
    chk(dtr | rts, 16'h0008);
    ring_req = 16'h0008;
    repeat (3) @(negedge clk);
    chk(scs_rd & 16'hf000, 16'hf000);
    chk(lms_rd & 16'h0016, 16'h0016);
    wr(0, 16'h0045);
    chk(lms_rd & 16'h0010, 16'h0000);
    ring_req = 16'h0000;
    bus_init = 1;
    @(negedge clk);
    bus_init = 0;
    chk(scs_rd | lms_rd | dtr | len, 16'h0000);
  endtask
  // clear mux drops terminal ready, clear scan holds busy for a bounded time
  task automatic t_clear();
    wr(0, 16'h0003);
    wr(1, 16'h0003);
    wr(0, 16'h0400);
    chk(dtr | len | (scs_rd & 16'h004f), 16'h0000);
    wr(0, 16'h0003);
    wr(1, 16'h0002);
    wr(0, 16'h0800);
    chk(scs_rd & 16'h0010, 16'h0010);
    chk(dtr | len, 16'h0008); // clear scan keeps terminal ready
    n = 0;
    while (scs_rd[SCS_BUSY_BIT] !== 1'b0 && n < 20) begin
      @(negedge clk);
      n++;
    end
    chk(16'(n), 16'(CLR_SCAN_CYC - 1)); // busy stood the whole clear
  endtask
  // go with address and enables, then master clear
  task automatic t_sys();
    sec_line = 4'h0;
    wr(2, 16'h37ff); // only go, address and enables may stick
    chk(sys_rd, 16'h3071);
    chk(16'(seq_idle), 16'h0001);
    wr(2, 16'h0800);
    chk(sys_rd | 16'(seq_idle), 16'h0000);
  endtask
  // modes, alternate start, marked count and all three ways of stopping: count end, software abort, memory error
  task automatic t_tx();
    sec_line = 4'h2;
    mode = 3'h5;
    wr(5, 16'h0000);
    mode = 3'h6;
    wr(6, 16'h0000);
    chk(16'({rxm_rd, txm_rd}), 16'h002e);
    wr(4, 16'h0084);
    chk(16'({ls_rd[LS_TX_GO_BIT], use_alt, marked}), 16'h0006);
    pri = 16'h0000; // a marked count gone to zero, alternate still busy
    repeat (2) @(negedge clk);
    chk(16'({ls_rd[LS_TX_GO_BIT], use_alt, marked}), 16'h0007);
    alt = 16'h0000;
    repeat (2) @(negedge clk);
    chk(ls_rd & 16'h0004, 16'h0000);
    {pri, alt} = 32'h0001_0001;
    wr(4, 16'h0004);
    chk(ls_rd & 16'h0004, 16'h0004);
    wr(4, 16'h0000);
    chk(ls_rd & 16'h0004, 16'h0000); // software abort
    wr(4, 16'h0004);
    mem_err = 1;
    repeat (2) @(negedge clk);
    mem_err = 0;
    chk(ls_rd & 16'h0004, 16'h0000);
  endtask
  // reception start, resync, sync found and shutdown
  task automatic t_rx();
    sec_line = 4'h4;
    wr(3, 16'h0003); // line format loaded before any enable
    wr(3, 16'ha403);
    chk(lc_rd, 16'ha403);
    wr(2, 16'h0001);
    chk(16'(seq_idle), 16'h0000); // receiver enabled, go skips idle straight into run
    wr(4, 16'h0002);
    chk(16'({disc_seen, lp_rd[7], ls_rd[1:0]}), 16'h000c);
    sync_found = 1; // a character arrives before any further resync
    @(negedge clk);
    sync_found = 0;
    @(negedge clk);
    chk(ls_rd & 16'h0003, 16'h0001);
    wr(3, 16'h8403);
    wr(4, 16'h0002);
    chk(16'({disc_seen, ls_rd[1:0]}), 16'h0004);
    chk(16'(seq_idle), 16'h0001); // no active line, back to idle loop
  endtask
  // main sequence
  initial begin
    repeat (10) @(negedge clk);
    rst_n = 1;
    repeat (4) @(negedge clk);
    chk(scs_rd | lms_rd | sys_rd | dtr | rts | len, 16'h0000);
    t_modem();
    t_clear();
    t_sys();
    t_tx();
    t_rx();
    conclude();
  end
  // a hang is cut short and counted
  initial begin
    #200000;
    fail_count++;
    conclude();
  end
endmodule : tb
`default_nettype wire
